// ===== hdl/dpt_pkg.sv
// Purpose: Shared constants and types for the single-wire potentiometer slave.
// Assumes: 50 MHz reference clock; all times are given in microseconds.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// [RQ1] Skip command after presence opens function commands
// [RQ2] Control write receives byte, echoes it back
// [RQ3] Control byte fields: wiper number, charge pump
// [RQ4] Position write receives byte, echoes it back
// [RQ5] Release code commits value, then status bits
// [RQ6] Status bits zero on success, one on failure
// [RQ7] Increment moves wiper up, returns new position
// [RQ8] Decrement moves wiper down, returns new position
// [RQ9] Master starts all signals except presence
// [RQ10] Regular speed unless overdrive; overdrive uses fast timing
// [RQ11] Master reset low: 480 us, 48 overdrive
// [RQ12] Presence: wait, then hold line low
// [RQ13] Reset of 480 us returns regular speed
// [RQ14] Overdrive kept across short reset up to 80
// [RQ15] Falling edge restarts slot timer, sets sampling
// [RQ16] Read zero holds line low; one never drives
// [RQ17] Master keeps reset plus rise under 960
// [RQ18] Master samples read data late in window
// [RQ19] Master leaves line high when suspending
// [RQ20] Overdrive skip command switches into overdrive
// [RQ21] Unknown function command: ignore until reset
package dpt_pkg;
	// Clock rate in cycles per microsecond
	localparam int unsigned CLK_MHZ        = 50;
	// Link times in microseconds, device side choices inside the allowed spans
	localparam int unsigned PDH_REG_US     = 30;
	localparam int unsigned PDH_OD_US      = 3;
	localparam int unsigned PDL_REG_US     = 120;
	localparam int unsigned PDL_OD_US      = 12;
	localparam int unsigned RST_REG_US     = 480;
	localparam int unsigned RST_OD_US      = 48;
	localparam int unsigned RST_OD_MAX_US  = 80;
	localparam int unsigned SAMP_REG_US    = 30;
	localparam int unsigned SAMP_OD_US     = 3;
	localparam int unsigned HOLD_REG_US    = 30;
	localparam int unsigned HOLD_OD_US     = 3;
	// Derived cycle counts (exact, the rate is a whole number per microsecond)
	localparam int unsigned PDH_REG_CYC    = PDH_REG_US * CLK_MHZ;
	localparam int unsigned PDH_OD_CYC     = PDH_OD_US * CLK_MHZ;
	localparam int unsigned PDL_OD_CYC     = PDL_OD_US * CLK_MHZ;
	localparam int unsigned RST_OD_CYC     = RST_OD_US * CLK_MHZ;
	localparam int unsigned RST_OD_MAX_CYC = RST_OD_MAX_US * CLK_MHZ;
	localparam int unsigned SAMP_REG_CYC   = SAMP_REG_US * CLK_MHZ;
	localparam int unsigned SAMP_OD_CYC    = SAMP_OD_US * CLK_MHZ;
	localparam int unsigned HOLD_REG_CYC   = HOLD_REG_US * CLK_MHZ;
	localparam int unsigned HOLD_OD_CYC    = HOLD_OD_US * CLK_MHZ;
	// Command bytes
	localparam logic [7:0] CMD_SKIP     = 8'hCC;
	localparam logic [7:0] CMD_OD_SKIP  = 8'h3C;
	localparam logic [7:0] CMD_WR_CTRL  = 8'h55;
	localparam logic [7:0] CMD_WR_POS   = 8'h0F;
	localparam logic [7:0] CMD_INC      = 8'hC3;
	localparam logic [7:0] CMD_DEC      = 8'h99;
	localparam logic [7:0] REL_CODE     = 8'h96;
	// Control byte layout and reset values
	localparam int unsigned WSEL_LO     = 0;
	localparam int unsigned WSEL_HI     = 1;
	localparam int unsigned PUMP_BIT    = 6;
	localparam logic [1:0] WSEL_ZERO    = 2'h0;
	localparam logic [7:0] CTRL_RST     = 8'h00;
	localparam logic [7:0] WIPER_RST    = 8'h00;
	localparam logic [7:0] WIPER_MAX    = 8'hFF;
	localparam logic [7:0] WIPER_MIN    = 8'h00;
	// Link phase
	typedef enum logic [1:0] {PH_IDLE, PH_SLOT, PH_PWAIT, PH_PDRV} dpt_phase_t;
	// Protocol state
	typedef enum logic [2:0] {PR_IGN, PR_ROM, PR_FUNC, PR_DATA, PR_ECHO, PR_REL, PR_STAT, PR_POS} dpt_proto_t;
	// Synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} dpt_sync_t;
	// Slave state
	typedef struct packed {
		logic       lvl;
		logic       od;
		logic [15:0] low_cnt;
		logic [15:0] tmr;
		dpt_phase_t ph;
		dpt_proto_t pr;
		logic [7:0] sh;
		logic [2:0] bit_n;
		logic       is_pos;
		logic [7:0] pend;
		logic [7:0] wiper;
		logic [7:0] ctrl;
		logic       fail;
		logic       drv;
	} dpt_state_t;
endpackage

// ===== hdl/dpt_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for the bus pin.
// Assumes: Idle level of the line is high.
// Notes: The first stage feeds only the second stage.
module dpt_sync (
	// Clock and control
	input  wire logic ref_clk_i,
	input  wire logic srst_i,
	input  wire logic ce_i,
	// Pin side
	input  wire logic din_i,
	// Filtered level
	output logic      lvl_o
);
	dpt_pkg::dpt_sync_t st_ff;   // Registered state
	dpt_pkg::dpt_sync_t nxt_st;  // Next state

	// Shift the pin in; accept a change once stages two and three agree
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = din_i;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		if (st_ff.s2 == st_ff.s3) begin
			nxt_st.lvl = st_ff.s3;
		end
	end

	// Reset to idle high so no false falling edge appears
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			st_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	assign lvl_o = st_ff.lvl;
endmodule

// ===== hdl/dpt_slave.sv
// Purpose: Device-side link and command logic of a single-wire digital potentiometer.
// Assumes: Single-drop bus; open-drain pin split into input, output and enable.
// Notes: Timing runs from bus edges; ROM addressing other than skip is not served.
module dpt_slave #(
	parameter int unsigned RST_REG_CYC = dpt_pkg::RST_REG_US * dpt_pkg::CLK_MHZ,
	parameter int unsigned PDL_REG_CYC = dpt_pkg::PDL_REG_US * dpt_pkg::CLK_MHZ
) (
	// Clock and control
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	input  wire logic       ce_i,
	// Bus pin
	input  wire logic       owire_i,
	output logic            owire_o,
	output logic            owire_oe_o,
	// Potentiometer state
	output logic [7:0]      wiper_pos_o,
	output logic [1:0]      wiper_number_select_o,
	output logic            charge_pump_control_o,
	output logic            overdrive_o
);
	// Counts must fit the 16-bit timers; the long reset must also outlast the longest
	// short overdrive reset, or an 80 us reset would wrongly drop overdrive
	if (RST_REG_CYC <= dpt_pkg::RST_OD_MAX_CYC || RST_REG_CYC > 65535 ||
	    PDL_REG_CYC < 2 || PDL_REG_CYC > 65535) begin : g_bad_cycles
		$error("dpt_slave: cycle count parameter out of range");
	end

	localparam logic [15:0] C_RST_REG    = 16'(RST_REG_CYC);
	localparam logic [15:0] C_PDL_REG    = 16'(PDL_REG_CYC);
	localparam logic [15:0] C_RST_OD     = 16'(dpt_pkg::RST_OD_CYC);
	localparam logic [15:0] C_RST_OD_MAX = 16'(dpt_pkg::RST_OD_MAX_CYC);
	localparam logic [15:0] C_PDH_REG    = 16'(dpt_pkg::PDH_REG_CYC);
	localparam logic [15:0] C_PDH_OD     = 16'(dpt_pkg::PDH_OD_CYC);
	localparam logic [15:0] C_PDL_OD     = 16'(dpt_pkg::PDL_OD_CYC);
	localparam logic [15:0] C_SAMP_REG   = 16'(dpt_pkg::SAMP_REG_CYC);
	localparam logic [15:0] C_SAMP_OD    = 16'(dpt_pkg::SAMP_OD_CYC);
	localparam logic [15:0] C_HOLD_REG   = 16'(dpt_pkg::HOLD_REG_CYC);
	localparam logic [15:0] C_HOLD_OD    = 16'(dpt_pkg::HOLD_OD_CYC);

	// Pick the fast or the regular figure, minus one for a zero-based timer
	function automatic logic [15:0] sel_end(input logic od, input logic [15:0] fast, input logic [15:0] slow);
		sel_end = (od ? fast : slow) - 16'h0001;
	endfunction

	// Saturating wiper step; the wiper stops at either end instead of wrapping
	function automatic logic [7:0] step_wiper(input logic [7:0] w, input logic up);
		if (up) begin
			step_wiper = (w == dpt_pkg::WIPER_MAX) ? w : w + 8'h01;
		end else begin
			step_wiper = (w == dpt_pkg::WIPER_MIN) ? w : w - 8'h01;
		end
	endfunction

	dpt_pkg::dpt_state_t st_ff;   // Registered state
	dpt_pkg::dpt_state_t nxt_st;  // Next state
	logic                line;    // Filtered bus level
	logic                rise;    // Line went high
	logic                fall;    // Line went low
	logic                is_tx;   // Current protocol state sends bits
	logic                tx_bit;  // Bit to send in the next read slot
	logic [7:0]          rx_byte; // Byte completed by the bit now sampled
	logic                bit_done;
	logic                byte_done;
	logic                rel_ok;  // Release code right and value acceptable

	// Pin filter
	dpt_sync u_sync (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.ce_i      (ce_i),
		.din_i     (owire_i),
		.lvl_o     (line)
	);

	// Link timing and command sequencing
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.lvl = line;
		rise      = !st_ff.lvl && line;
		fall      = st_ff.lvl && !line;
		is_tx     = (st_ff.pr == dpt_pkg::PR_ECHO) || (st_ff.pr == dpt_pkg::PR_STAT) || (st_ff.pr == dpt_pkg::PR_POS);
		tx_bit    = (st_ff.pr == dpt_pkg::PR_STAT) ? st_ff.fail : st_ff.sh[0]; // [RQ6]
		rx_byte   = {line, st_ff.sh[7:1]}; // [RQ1]
		bit_done  = 1'b0;
		byte_done = 1'b0;
		rel_ok    = (rx_byte == dpt_pkg::REL_CODE) &&
		            (st_ff.is_pos || st_ff.pend[dpt_pkg::WSEL_HI:dpt_pkg::WSEL_LO] == dpt_pkg::WSEL_ZERO); // [RQ3]
		// Low-time counter, saturating so a stuck line never wraps to short
		if (!line) begin
			nxt_st.low_cnt = (st_ff.low_cnt == 16'hFFFF) ? st_ff.low_cnt : st_ff.low_cnt + 16'h0001;
		end else begin
			nxt_st.low_cnt = 16'h0000;
		end
		case (st_ff.ph)
			dpt_pkg::PH_PWAIT: begin
				// Wait after the reset rise before answering
				nxt_st.tmr = st_ff.tmr + 16'h0001;
				if (st_ff.tmr >= sel_end(st_ff.od, C_PDH_OD, C_PDH_REG)) begin // [RQ12]
					nxt_st.ph  = dpt_pkg::PH_PDRV;
					nxt_st.tmr = 16'h0000;
					nxt_st.drv = 1'b1; // [RQ9]
				end
			end
			dpt_pkg::PH_PDRV: begin
				// Presence low, speed chosen by the current mode
				nxt_st.tmr = st_ff.tmr + 16'h0001;
				if (st_ff.tmr >= sel_end(st_ff.od, C_PDL_OD, C_PDL_REG)) begin // [RQ12] [RQ10]
					nxt_st.ph  = dpt_pkg::PH_IDLE;
					nxt_st.drv = 1'b0;
				end
			end
			dpt_pkg::PH_SLOT: begin
				// Slot in progress: release after the hold, or sample the line
				nxt_st.tmr = st_ff.tmr + 16'h0001;
				if (is_tx && st_ff.tmr >= sel_end(st_ff.od, C_HOLD_OD, C_HOLD_REG)) begin // [RQ16]
					nxt_st.drv = 1'b0;
					nxt_st.ph  = dpt_pkg::PH_IDLE;
					bit_done   = 1'b1;
				end else if (!is_tx && st_ff.tmr >= sel_end(st_ff.od, C_SAMP_OD, C_SAMP_REG)) begin // [RQ15]
					nxt_st.ph  = dpt_pkg::PH_IDLE;
					bit_done   = 1'b1;
				end
			end
			default: begin
				// Master falling edge opens a slot and restarts the timer
				if (fall && st_ff.pr != dpt_pkg::PR_IGN) begin // [RQ15] [RQ21]
					nxt_st.ph  = dpt_pkg::PH_SLOT;
					nxt_st.tmr = 16'h0000;
					nxt_st.drv = is_tx && !tx_bit; // [RQ16]
				end
			end
		endcase
		// Shift the finished bit, least significant first
		if (bit_done) begin
			nxt_st.bit_n = st_ff.bit_n + 3'h1;
			byte_done    = (st_ff.bit_n == 3'h7);
			nxt_st.sh    = is_tx ? {1'b1, st_ff.sh[7:1]} : rx_byte; // [RQ1]
		end
		// Act on a whole byte
		if (byte_done) begin
			case (st_ff.pr)
				dpt_pkg::PR_ROM: begin
					if (rx_byte == dpt_pkg::CMD_SKIP) begin // [RQ1]
						nxt_st.pr = dpt_pkg::PR_FUNC;
					end else if (rx_byte == dpt_pkg::CMD_OD_SKIP) begin // [RQ20]
						nxt_st.pr = dpt_pkg::PR_FUNC;
						nxt_st.od = 1'b1;
					end else begin
						nxt_st.pr = dpt_pkg::PR_IGN;
					end
				end
				dpt_pkg::PR_FUNC: begin
					if (rx_byte == dpt_pkg::CMD_WR_CTRL) begin // [RQ2]
						nxt_st.pr     = dpt_pkg::PR_DATA;
						nxt_st.is_pos = 1'b0;
					end else if (rx_byte == dpt_pkg::CMD_WR_POS) begin // [RQ4]
						nxt_st.pr     = dpt_pkg::PR_DATA;
						nxt_st.is_pos = 1'b1;
					end else if (rx_byte == dpt_pkg::CMD_INC) begin // [RQ7]
						nxt_st.wiper = step_wiper(st_ff.wiper, 1'b1);
						nxt_st.sh    = step_wiper(st_ff.wiper, 1'b1);
						nxt_st.pr    = dpt_pkg::PR_POS;
					end else if (rx_byte == dpt_pkg::CMD_DEC) begin // [RQ8]
						nxt_st.wiper = step_wiper(st_ff.wiper, 1'b0);
						nxt_st.sh    = step_wiper(st_ff.wiper, 1'b0);
						nxt_st.pr    = dpt_pkg::PR_POS;
					end else begin
						nxt_st.pr = dpt_pkg::PR_IGN; // [RQ21]
					end
				end
				dpt_pkg::PR_DATA: begin
					// Hold the value and send it straight back
					nxt_st.pend = rx_byte; // [RQ2] [RQ4]
					nxt_st.sh   = rx_byte;
					nxt_st.pr   = dpt_pkg::PR_ECHO;
				end
				dpt_pkg::PR_ECHO: begin
					nxt_st.pr = dpt_pkg::PR_REL;
				end
				dpt_pkg::PR_REL: begin
					// Commit only on the release code
					if (rel_ok && st_ff.is_pos) begin // [RQ5]
						nxt_st.wiper = st_ff.pend;
					end else if (rel_ok) begin
						nxt_st.ctrl = st_ff.pend;
					end
					nxt_st.fail = !rel_ok;
					nxt_st.pr   = dpt_pkg::PR_STAT;
				end
				dpt_pkg::PR_POS: begin
					// Further steps may follow in the same transaction
					nxt_st.pr = dpt_pkg::PR_FUNC; // [RQ7]
				end
				default: begin
					nxt_st.pr = st_ff.pr;
				end
			endcase
		end
		// Reset pulse seen at the rise: it overrides any slot in progress
		if (rise && st_ff.ph != dpt_pkg::PH_PDRV &&
		    (st_ff.low_cnt >= C_RST_REG || (st_ff.od && st_ff.low_cnt >= C_RST_OD))) begin // [RQ11]
			nxt_st.od    = st_ff.od && (st_ff.low_cnt < C_RST_REG); // [RQ13] [RQ14]
			nxt_st.ph    = dpt_pkg::PH_PWAIT;
			nxt_st.tmr   = 16'h0000;
			nxt_st.drv   = 1'b0;
			nxt_st.pr    = dpt_pkg::PR_ROM;
			nxt_st.bit_n = 3'h0;
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			st_ff <= '{lvl: 1'b1, od: 1'b0, low_cnt: 16'h0000, tmr: 16'h0000, ph: dpt_pkg::PH_IDLE,
			           pr: dpt_pkg::PR_IGN, sh: 8'h00, bit_n: 3'h0, is_pos: 1'b0, pend: 8'h00,
			           wiper: dpt_pkg::WIPER_RST, ctrl: dpt_pkg::CTRL_RST, fail: 1'b0, drv: 1'b0}; // [RQ10]
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	// Open drain: only ever pulls low
	assign owire_o               = 1'b0;
	assign owire_oe_o            = st_ff.drv;
	assign wiper_pos_o           = st_ff.wiper;
	assign wiper_number_select_o = st_ff.ctrl[dpt_pkg::WSEL_HI:dpt_pkg::WSEL_LO]; // [RQ3]
	assign charge_pump_control_o = st_ff.ctrl[dpt_pkg::PUMP_BIT];
	assign overdrive_o           = st_ff.od;

	od_exit_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ13]
		(rise && st_ff.ph != dpt_pkg::PH_PDRV && st_ff.low_cnt >= C_RST_REG) |=> (!st_ff.od && st_ff.ph == dpt_pkg::PH_PWAIT))
		else $error("long reset did not return to regular speed");
	od_keep_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ14]
		(rise && st_ff.od && st_ff.ph != dpt_pkg::PH_PDRV && st_ff.low_cnt >= C_RST_OD && st_ff.low_cnt <= C_RST_OD_MAX)
		|=> (st_ff.od && st_ff.ph == dpt_pkg::PH_PWAIT))
		else $error("short reset left overdrive");
	od_enter_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ20]
		(byte_done && st_ff.pr == dpt_pkg::PR_ROM && rx_byte == dpt_pkg::CMD_OD_SKIP && !rise) |=> (st_ff.od && st_ff.pr == dpt_pkg::PR_FUNC))
		else $error("overdrive skip did not enter overdrive");
	echo_byte_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ2]
		(byte_done && st_ff.pr == dpt_pkg::PR_DATA && !rise) |=> (st_ff.pr == dpt_pkg::PR_ECHO && st_ff.sh == $past(rx_byte)))
		else $error("echo byte differs from received byte");
	bad_release_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ5]
		(byte_done && st_ff.pr == dpt_pkg::PR_REL && rx_byte != dpt_pkg::REL_CODE)
		|=> (st_ff.fail && st_ff.wiper == $past(st_ff.wiper) && st_ff.ctrl == $past(st_ff.ctrl)))
		else $error("value committed without release code");
	wiper_inc_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ7]
		(byte_done && st_ff.pr == dpt_pkg::PR_FUNC && rx_byte == dpt_pkg::CMD_INC && st_ff.wiper != dpt_pkg::WIPER_MAX)
		|=> (st_ff.wiper == $past(st_ff.wiper) + 8'h01 && st_ff.sh == st_ff.wiper))
		else $error("increment gave wrong position");
	wiper_dec_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ8]
		(byte_done && st_ff.pr == dpt_pkg::PR_FUNC && rx_byte == dpt_pkg::CMD_DEC && st_ff.wiper != dpt_pkg::WIPER_MIN)
		|=> (st_ff.wiper == $past(st_ff.wiper) - 8'h01 && st_ff.sh == st_ff.wiper))
		else $error("decrement gave wrong position");
	ignore_quiet_a : assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ21]
		(st_ff.pr == dpt_pkg::PR_IGN) |-> !owire_oe_o)
		else $error("line driven while ignoring");
	read_one_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ16]
		(fall && st_ff.ph == dpt_pkg::PH_IDLE && is_tx && tx_bit && !rise) |=> (st_ff.ph == dpt_pkg::PH_SLOT && !owire_oe_o))
		else $error("line pulled low for a one");
	status_bits_a : assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ6]
		(st_ff.pr == dpt_pkg::PR_STAT && st_ff.ph == dpt_pkg::PH_SLOT && owire_oe_o) |-> !st_ff.fail)
		else $error("zero sent after failed update");
	presence_a : assert property (@(posedge ref_clk_i) disable iff (srst_i || !ce_i) // [RQ12]
		(st_ff.ph == dpt_pkg::PH_PDRV && st_ff.tmr < sel_end(st_ff.od, C_PDL_OD, C_PDL_REG)) |=> owire_oe_o)
		else $error("presence released early");
endmodule

// ===== tb/dpt_master_model.sv
// Purpose: Behavioural bus master that drives reset pulses and time slots on the shared line.
// Assumes: The line has a pull-up; the master only pulls low and otherwise releases it.
// Notes: Timing is given in clock cycles; the bench picks the speed through fast.
module dpt_master_model (
	// Clock
	input  wire logic ref_clk_i,
	// Resolved line level
	input  wire logic line_i,
	// High while the master pulls the line low
	output logic      pull_o
);
	timeunit 1ns;
	timeprecision 1ps;

	bit fast; // Speed the master believes the device runs at

	// Line released from time zero, so it idles high between transactions
	initial pull_o = 1'b0;

	// Pick a cycle figure for the current speed
	function automatic int unsigned sl(input int unsigned reg_c, input int unsigned od_c);
		return fast ? od_c : reg_c;
	endfunction

	// Wait a number of falling edges, where all master changes happen
	task automatic hold(input int unsigned n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	// Reset pulse, then measure the presence wait and presence low length
	task automatic bus_reset(input int unsigned low_c, output int unsigned dly, output int unsigned len);
		dly = 0;
		len = 0;
		pull_o <= 1'b1;
		hold(low_c);
		pull_o <= 1'b0;
		hold(1);
		// Bounded waits so a silent device cannot hang the master
		while (line_i && dly < 5000) begin
			hold(1);
			dly++;
		end
		while (!line_i && len < 10000) begin
			hold(1);
			len++;
		end
		hold(sl(200, 40));
	endtask

	// One slot: a short low sends a one or opens a read, a long low sends a zero
	task automatic slot(input logic wbit, output logic rbit);
		int unsigned low;
		int unsigned smp;
		low = wbit ? 20 : sl(1550, 170); // Zero low outlasts the device sample point
		smp = sl(600, 80);
		rbit = 1'b1;
		for (int i = 0; i < int'(sl(1600, 190)); i++) begin
			pull_o <= (i < low);
			// Late sample, still well inside the read-zero hold
			if (i == smp) begin
				rbit = line_i;
			end
			hold(1);
		end
	endtask

	// Send a byte, least significant bit first
	task automatic put_byte(input logic [7:0] b);
		logic r;
		for (int i = 0; i < 8; i++) begin
			slot(b[i], r);
		end
	endtask

	// Read a byte, least significant bit first
	task automatic get_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			slot(1'b1, b[i]);
		end
	endtask
endmodule

// ===== tb/single_wire_digipot_slave_tb.sv
// Purpose: Self-checking bench for the potentiometer slave against a behavioural master.
// Assumes: Reset threshold and presence low are shortened through the slave parameters.
// Notes: Table rows cover register writes; speed changes and odd bytes are hand-written.
`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
		end \
	end

module single_wire_digipot_slave_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned RST_C  = 4100;   // Shortened reset threshold, above any slot low and the 80 us short reset
	localparam int unsigned PDL_C  = 100;    // Shortened regular presence low
	localparam int unsigned WD_CYC = 250000; // About 1.7 times the expected run

	// One register-write transaction and what it should leave behind
	typedef struct {
		logic [7:0] cmd;
		logic [7:0] val;
		logic [7:0] rel;
		logic [7:0] st;
		logic [7:0] wip;
		logic [7:0] ctl;
	} dpt_row_t;

	logic       ref_clk_i = 1'b0;
	logic       srst_i;
	logic       ce_i;
	logic       pull;        // Master pulling low
	logic       oe;          // Device pulling low
	logic       o;           // Device output level, open drain
	wire logic  line;        // Resolved line with pull-up
	logic [7:0] wiper;
	logic [1:0] wsel;
	logic       pump;
	logic       od;
	int         miscompares  = 0;
	int         total_checks = 0;
	dpt_row_t   rows [4] = '{
		'{8'h55, 8'h4C, 8'h96, 8'h00, 8'h01, 8'h4C}, // Control write commits
		'{8'h0F, 8'h7F, 8'h96, 8'h00, 8'h7F, 8'h4C}, // Mid-scale position commits
		'{8'h0F, 8'h20, 8'h69, 8'hFF, 8'h7F, 8'h4C}, // Wrong release keeps position
		'{8'h55, 8'h4D, 8'h96, 8'hFF, 8'h7F, 8'h4C}  // Wiper number one is refused
	};

	// Either party pulling low wins; otherwise the pull-up holds it high
	assign line = !(pull || (oe && !o));

	always #10 ref_clk_i = ~ref_clk_i;

	dpt_slave #(.RST_REG_CYC(RST_C), .PDL_REG_CYC(PDL_C)) dut (
		.ref_clk_i            (ref_clk_i),
		.srst_i               (srst_i),
		.ce_i                 (ce_i),
		.owire_i              (line),
		.owire_o              (o),
		.owire_oe_o           (oe),
		.wiper_pos_o          (wiper),
		.wiper_number_select_o(wsel),
		.charge_pump_control_o(pump),
		.overdrive_o          (od)
	);

	dpt_master_model m (
		.ref_clk_i(ref_clk_i),
		.line_i   (line),
		.pull_o   (pull)
	);

	// Verdict and end of run, shared by the main sequence and the watchdog
	task automatic complete_run();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Reset pulse, then presence timing for the speed the device should be at
	task automatic open_link(input int unsigned low_c, input bit fast_exp);
		int unsigned d;
		int unsigned l;
		int unsigned pdh;
		int unsigned pdl;
		pdh = fast_exp ? dpt_pkg::PDH_OD_CYC : dpt_pkg::PDH_REG_CYC;
		pdl = fast_exp ? dpt_pkg::PDL_OD_CYC : PDL_C;
		m.bus_reset(low_c, d, l);
		`CHK(od, fast_exp)
		`CHK(d + 2 >= pdh && d <= pdh + 10, 1'b1)
		`CHK(l + 2 >= pdl && l <= pdl + 2, 1'b1)
	endtask

	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (WD_CYC) @(posedge ref_clk_i);
		miscompares++;
		complete_run();
	end

	// Main sequence
	initial begin
		logic [7:0]  b;
		logic [15:0] steps [3];
		srst_i = 1'b1;
		ce_i   = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		`CHK({wiper, wsel, pump, od, oe, o}, 14'h0000)
		srst_i <= 1'b0;
		m.hold(10);
		// Regular speed: increment from the reset position
		m.fast = 1'b0;
		open_link(4400, 1'b0);
		m.put_byte(dpt_pkg::CMD_SKIP);
		m.put_byte(dpt_pkg::CMD_INC);
		m.get_byte(b);
		`CHK(b, 8'h01)
		// Switch to overdrive
		open_link(4400, 1'b0);
		m.put_byte(dpt_pkg::CMD_OD_SKIP);
		`CHK(od, 1'b1)
		m.fast = 1'b1;
		// Register writes with echo, release and status bits
		foreach (rows[i]) begin
			open_link(2500, 1'b1);
			m.put_byte(dpt_pkg::CMD_SKIP);
			m.put_byte(rows[i].cmd);
			m.put_byte(rows[i].val);
			m.get_byte(b);
			`CHK(b, rows[i].val)
			m.put_byte(rows[i].rel);
			m.get_byte(b);
			`CHK(b, rows[i].st)
			`CHK({wiper, wsel, pump}, {rows[i].wip, rows[i].ctl[1:0], rows[i].ctl[6]})
		end
		// Increment twice and decrement once within one transaction
		steps[0] = 16'hC380;
		steps[1] = 16'hC381;
		steps[2] = 16'h9980;
		open_link(2500, 1'b1);
		m.put_byte(dpt_pkg::CMD_SKIP);
		foreach (steps[i]) begin
			m.put_byte(steps[i][15:8]);
			m.get_byte(b);
			`CHK(b, steps[i][7:0])
		end
		// Unknown function byte: device falls silent until the next reset
		open_link(2500, 1'b1);
		m.put_byte(dpt_pkg::CMD_SKIP);
		m.put_byte(8'hA5);
		m.put_byte(dpt_pkg::CMD_INC);
		m.get_byte(b);
		`CHK({b, wiper}, 16'hFF80)
		// Unserved address byte: no function command is taken
		open_link(2500, 1'b1);
		m.put_byte(8'h33);
		m.put_byte(dpt_pkg::CMD_INC);
		m.get_byte(b);
		`CHK({b, wiper}, 16'hFF80)
		// Long reset returns the device to regular speed
		m.fast = 1'b0;
		open_link(4400, 1'b0);
		// Reset in mid-run clears the committed values
		srst_i <= 1'b1;
		m.hold(2);
		srst_i <= 1'b0;
		m.hold(2);
		`CHK({wiper, wsel, pump, od, oe}, 13'h0000)
		complete_run();
	end
endmodule
